/* File: shared/trigger_arm_force_delay_params.svh */
`ifndef TRIGGER_ARM_FORCE_DELAY_PARAMS_SVH
`define TRIGGER_ARM_FORCE_DELAY_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_W 16
`define DATA_W 64
`define ADDR_CARD_COMMAND 16'h0064
`define ADDR_TRIGGER_OR_SELECT 16'h9dda
`define ADDR_MAX_DELAY_CAPABILITY 16'h9f60
`define ADDR_TRIGGER_DELAY_COUNT 16'h9f6a

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ARM_TRIGGER_CMD_BIT 3
`define FORCE_TRIGGER_CMD_BIT 4
`define DISARM_TRIGGER_CMD_BIT 5
`define SOFTWARE_EVENT_BIT 0
`define OR_W 32
`define DELAY_STEP_BITS 5

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define OR_SELECT_RESET 32'h0000_0001
`define DELAY_RESET 64'h0000_0000_0000_0000
`define DELAY_MAX 64'h0000_003f_ffff_ffe0
`define CNT_W 38

`endif

/* File: shared/trigger_arm_force_delay_pkg.sv */
`include "trigger_arm_force_delay_params.svh"
`default_nettype none
package trigger_arm_force_delay_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SETUP = 5'h02,
        ST_WAIT = 5'h04,
        ST_DELAY = 5'h08,
        ST_POST = 5'h10
    } trigState_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
    } regReq_s;

    typedef struct packed {
        trigState_e state;
        logic armed;
        logic [`OR_W-1:0] orMask;
        logic [`DATA_W-1:0] delay;
        logic [`CNT_W-1:0] cnt;
        logic trigEvent;
        logic hubTrigOut;
        logic waiting;
        logic [`DATA_W-1:0] rdData;
        logic rdValid;
    } engState_s;

endpackage
`default_nettype wire

/* File: verilog/trigger_arm_force_delay.sv */
// Notes on behaviour
// - Software bit in OR mask triggers at once when started and armed.
// - Start-to-trigger covers board setup plus pre-trigger recording.
// - Force command injects a trigger only while waiting; else ignored.
// - Each force command accepted while waiting makes exactly one trigger event.
// - After a trigger the engine returns to waiting in its programmed mode.
// - Arm command enables recognition of events from enabled sources.
// - Disarm stops recognition of all events except force commands and, in hub mode, the hub result.
// - Engine comes out of reset disarmed.
// - OR mask is read/write and selects events ORed into the decision.
// - Delay stage is last in the chain, after source selection.
// - Hub combines undelayed events; each card delays the result itself.
// - Delay counts sample clocks.
// - Zero delay adds nothing beyond fixed internal latency.
// - Nonzero delay lies in 32..maximum in steps of 32.
// - Read-only capability register reports the largest delay.
// - Delay shifts only the trigger, not the pre/post split.
`include "trigger_arm_force_delay_params.svh"
`default_nettype none

module trigger_arm_force_delay
    import trigger_arm_force_delay_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire regReq_s regReq,
    output logic [`DATA_W-1:0] rdData,
    output logic rdValid,
    input wire logic cardRun,
    input wire logic acqReady,
    input wire logic segmentDone,
    input wire logic [`OR_W-1:0] srcEvents,
    input wire logic hubEnable,
    input wire logic hubTrigIn,
    output logic hubTrigOut,
    output logic trigEvent,
    output logic armed,
    output logic waiting
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rstSync_reg;
    logic rstN;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end

    assign rstN = rstSync_reg[1];

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    engState_s r_reg;
    engState_s r_next;
    logic cmdWr;
    logic armCmd;
    logic disarmCmd;
    logic forceCmd;
    logic orWr;
    logic delayWr;
    logic [`DATA_W-1:0] delayMasked;
    logic [`OR_W-1:0] eventVec;
    logic orHit;
    logic localHit;
    logic accept;

    assign cmdWr = regReq.wr && (regReq.addr == `ADDR_CARD_COMMAND);
    // Decoded fresh on each write, nothing held afterwards
    assign armCmd = cmdWr && regReq.wdata[`ARM_TRIGGER_CMD_BIT];
    assign disarmCmd = cmdWr && regReq.wdata[`DISARM_TRIGGER_CMD_BIT];
    assign forceCmd = cmdWr && regReq.wdata[`FORCE_TRIGGER_CMD_BIT];
    assign orWr = regReq.wr && (regReq.addr == `ADDR_TRIGGER_OR_SELECT);
    assign delayWr = regReq.wr && (regReq.addr == `ADDR_TRIGGER_DELAY_COUNT);

    // Step of 32 enforced, out-of-range clipped to the maximum
    always_comb begin
        delayMasked = {regReq.wdata[`DATA_W-1:`DELAY_STEP_BITS],
                       {`DELAY_STEP_BITS{1'b0}}};
        if (delayMasked > `DELAY_MAX) begin
            delayMasked = `DELAY_MAX;
        end
    end

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    // Software event is always present; the mask decides
    always_comb begin
        eventVec = srcEvents;
        eventVec[`SOFTWARE_EVENT_BIT] = 1'b1;
    end

    assign orHit = |(r_reg.orMask & eventVec);
    // Force bypasses the arm gate
    assign localHit = (r_reg.armed && orHit) || forceCmd;
    // Hub mode delays the combined undelayed result instead
    assign accept = (r_reg.state == ST_WAIT) && cardRun &&
                    (hubEnable ? hubTrigIn : localHit);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.trigEvent = 1'b0;
        r_next.hubTrigOut = 1'b0;
        r_next.rdValid = 1'b0;

        if (disarmCmd) begin
            r_next.armed = 1'b0;
        end else if (armCmd) begin
            r_next.armed = 1'b1;
        end
        if (orWr) begin
            r_next.orMask = regReq.wdata[`OR_W-1:0];
        end
        if (delayWr) begin
            r_next.delay = delayMasked;
        end

        if (regReq.rd) begin
            r_next.rdValid = 1'b1;
            case (regReq.addr)
                `ADDR_TRIGGER_OR_SELECT: begin
                    r_next.rdData = {{(`DATA_W-`OR_W){1'b0}}, r_reg.orMask};
                end
                `ADDR_MAX_DELAY_CAPABILITY: begin
                    r_next.rdData = `DELAY_MAX;
                end
                `ADDR_TRIGGER_DELAY_COUNT: begin
                    r_next.rdData = r_reg.delay;
                end
                default: begin
                    r_next.rdData = '0;
                end
            endcase
        end

        case (r_reg.state)
            ST_IDLE: begin
                if (cardRun) begin
                    r_next.state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (!cardRun) begin
                    r_next.state = ST_IDLE;
                end else if (acqReady) begin
                    // Waits for setup and pre-trigger fill
                    r_next.state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Undelayed local decision goes out to the hub
                r_next.hubTrigOut = cardRun && localHit;
                if (!cardRun) begin
                    r_next.state = ST_IDLE;
                end else if (accept) begin
                    // One event per accept, delay after selection
                    r_next.state = ST_DELAY;
                    r_next.cnt = r_reg.delay[`CNT_W-1:0];
                end
            end
            ST_DELAY: begin
                if (!cardRun) begin
                    r_next.state = ST_IDLE;
                end else if (r_reg.cnt == '0) begin
                    // Only the event moves; sizing is not touched here
                    r_next.trigEvent = 1'b1;
                    r_next.state = ST_POST;
                end else begin
                    r_next.cnt = r_reg.cnt - `CNT_W'(1);
                end
            end
            ST_POST: begin
                if (!cardRun) begin
                    r_next.state = ST_IDLE;
                end else if (segmentDone) begin
                    r_next.state = ST_SETUP;
                end
            end
            default: begin
                r_next.state = ST_IDLE;
            end
        endcase
        r_next.waiting = (r_next.state == ST_WAIT);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            r_reg.state <= ST_IDLE;
            r_reg.armed <= 1'b0;
            r_reg.orMask <= `OR_SELECT_RESET;
            r_reg.delay <= `DELAY_RESET;
            r_reg.cnt <= '0;
            r_reg.trigEvent <= 1'b0;
            r_reg.hubTrigOut <= 1'b0;
            r_reg.waiting <= 1'b0;
            r_reg.rdData <= '0;
            r_reg.rdValid <= 1'b0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign rdData = r_reg.rdData;
    assign rdValid = r_reg.rdValid;
    assign hubTrigOut = r_reg.hubTrigOut;
    assign trigEvent = r_reg.trigEvent;
    assign armed = r_reg.armed;
    assign waiting = r_reg.waiting;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_softwareReady;
        r_reg.state == ST_WAIT && cardRun && r_reg.armed &&
            r_reg.orMask[`SOFTWARE_EVENT_BIT] && !hubEnable;
    endsequence

    sequence s_zeroAccept;
        accept && r_reg.delay == '0 ##1 cardRun;
    endsequence

    property p_software_fires;
        @(posedge ref_clk) disable iff (!rstN)
        s_softwareReady |=> r_reg.state == ST_DELAY;
    endproperty
    a_software_fires: assert property (p_software_fires)
        else $error("software event did not start the delay stage");

    property p_setup_gate;
        @(posedge ref_clk) disable iff (!rstN)
        (r_reg.state == ST_SETUP && !acqReady) |=> r_reg.state != ST_WAIT;
    endproperty
    a_setup_gate: assert property (p_setup_gate)
        else $error("waiting began before setup and pre-trigger ended");

    property p_force_ignored;
        @(posedge ref_clk) disable iff (!rstN)
        (forceCmd && r_reg.state == ST_POST && cardRun && !segmentDone)
            |=> r_reg.state == ST_POST && !r_reg.trigEvent;
    endproperty
    a_force_ignored: assert property (p_force_ignored)
        else $error("force acted while not waiting");

    property p_single_event;
        @(posedge ref_clk) disable iff (!rstN)
        r_reg.trigEvent |=> !r_reg.trigEvent;
    endproperty
    a_single_event: assert property (p_single_event)
        else $error("trigger pulse longer than one cycle");

    property p_resume;
        @(posedge ref_clk) disable iff (!rstN)
        (r_reg.state == ST_POST && segmentDone && cardRun)
            ##1 (cardRun && acqReady) |=> r_reg.state == ST_WAIT;
    endproperty
    a_resume: assert property (p_resume)
        else $error("engine did not return to waiting");

    property p_arm;
        @(posedge ref_clk) disable iff (!rstN)
        (armCmd && !disarmCmd) |=> r_reg.armed;
    endproperty
    a_arm: assert property (p_arm)
        else $error("arm command did not arm");

    property p_disarmed_blocks;
        @(posedge ref_clk) disable iff (!rstN)
        (!r_reg.armed && r_reg.state == ST_WAIT && !forceCmd && !hubEnable)
            |=> r_reg.state != ST_DELAY;
    endproperty
    a_disarmed_blocks: assert property (p_disarmed_blocks)
        else $error("event recognised while disarmed");

    property p_force_when_disarmed;
        @(posedge ref_clk) disable iff (!rstN)
        (forceCmd && r_reg.state == ST_WAIT && cardRun && !hubEnable)
            |=> r_reg.state == ST_DELAY;
    endproperty
    a_force_when_disarmed: assert property (p_force_when_disarmed)
        else $error("force while waiting was lost");

    property p_reset_disarmed;
        @(posedge ref_clk) $rose(rstN) |-> !r_reg.armed;
    endproperty
    a_reset_disarmed: assert property (p_reset_disarmed)
        else $error("engine armed out of reset");

    property p_or_write;
        @(posedge ref_clk) disable iff (!rstN)
        orWr |=> r_reg.orMask == $past(regReq.wdata[`OR_W-1:0]);
    endproperty
    a_or_write: assert property (p_or_write)
        else $error("OR mask not stored");

    property p_delay_last;
        @(posedge ref_clk) disable iff (!rstN)
        r_reg.trigEvent |-> $past(r_reg.state) == ST_DELAY;
    endproperty
    a_delay_last: assert property (p_delay_last)
        else $error("trigger bypassed the delay stage");

    property p_hub_result;
        @(posedge ref_clk) disable iff (!rstN)
        (r_reg.state == ST_WAIT && hubEnable && hubTrigIn && cardRun)
            |=> r_reg.state == ST_DELAY;
    endproperty
    a_hub_result: assert property (p_hub_result)
        else $error("hub result not delayed locally");

    property p_count_down;
        @(posedge ref_clk) disable iff (!rstN)
        (r_reg.state == ST_DELAY && r_reg.cnt != '0 && cardRun)
            |=> r_reg.cnt == $past(r_reg.cnt) - `CNT_W'(1);
    endproperty
    a_count_down: assert property (p_count_down)
        else $error("delay counter skipped a sample clock");

    property p_zero_delay;
        @(posedge ref_clk) disable iff (!rstN)
        s_zeroAccept |=> r_reg.trigEvent;
    endproperty
    a_zero_delay: assert property (p_zero_delay)
        else $error("zero delay added latency");

    property p_delay_range;
        @(posedge ref_clk) disable iff (!rstN)
        r_reg.delay <= `DELAY_MAX;
    endproperty
    a_delay_range: assert property (p_delay_range)
        else $error("delay above maximum");

    property p_capability;
        @(posedge ref_clk) disable iff (!rstN)
        (regReq.rd && regReq.addr == `ADDR_MAX_DELAY_CAPABILITY)
            |=> rdValid && rdData == `DELAY_MAX;
    endproperty
    a_capability: assert property (p_capability)
        else $error("capability read wrong");

    property p_step;
        @(posedge ref_clk) disable iff (!rstN)
        r_reg.delay[`DELAY_STEP_BITS-1:0] == '0;
    endproperty
    a_step: assert property (p_step)
        else $error("delay not a multiple of the step");

    property p_no_retention;
        @(posedge ref_clk) disable iff (!rstN)
        (r_reg.state == ST_WAIT && !r_reg.armed && !cmdWr && !hubEnable)
            |=> r_reg.state != ST_DELAY;
    endproperty
    a_no_retention: assert property (p_no_retention)
        else $error("command acted without a write");

endmodule

`default_nettype wire

/* File: tb/trigger_arm_force_delay_test.sv */
`include "trigger_arm_force_delay_params.svh"
`default_nettype none
module trigger_arm_force_delay_test
    import trigger_arm_force_delay_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Design hookup
    // ------------------------------------------------------------
    logic refClk = 1'b0;
    logic arstN;
    regReq_s regReq;
    logic [`DATA_W-1:0] rdData;
    logic rdValid;
    logic cardRun;
    logic acqReady;
    logic segmentDone;
    logic [`OR_W-1:0] srcEvents;
    logic hubEnable;
    logic hubTrigIn;
    logic hubTrigOut;
    logic trigEvent;
    logic armed;
    logic waiting;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    int nTrig = 0;
    integer seed = 12798;

    trigger_arm_force_delay DUT (
        .ref_clk(refClk), .arst_n(arstN), .regReq(regReq),
        .rdData(rdData), .rdValid(rdValid), .cardRun(cardRun),
        .acqReady(acqReady), .segmentDone(segmentDone),
        .srcEvents(srcEvents), .hubEnable(hubEnable),
        .hubTrigIn(hubTrigIn), .hubTrigOut(hubTrigOut),
        .trigEvent(trigEvent), .armed(armed), .waiting(waiting)
    );

    always #50 refClk = ~refClk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge refClk) begin
        cycles++;
        if (trigEvent === 1'b1)
            nTrig++;
        if (cycles > 20000) begin
            fails++;
            $display("run stopped by cycle limit");
            close_out();
        end
    end

    task automatic tick(int n = 1);
        repeat (n) begin
            @(posedge refClk);
            #10;
        end
    endtask

    task automatic check(logic [63:0] seen, logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Stored delay: whole steps only, clipped to the largest step
    function automatic logic [63:0] expDelay(logic [63:0] w);
        logic [63:0] m;
        m = w & ~((64'h1 << `DELAY_STEP_BITS) - 64'h1);
        if (m > `DELAY_MAX)
            m = `DELAY_MAX;
        return m;
    endfunction

    // Accept edge, one edge per delay count, then the pulse edge
    function automatic int expLatency(logic [63:0] w);
        return 2 + int'(expDelay(w));
    endfunction

    task automatic wr(logic [15:0] a, logic [63:0] d);
        regReq.wr = 1'b1;
        regReq.addr = a;
        regReq.wdata = d;
        tick();
        regReq.wr = 1'b0;
        tick();
    endtask

    task automatic rd(logic [15:0] a, output logic [63:0] d);
        int k;
        k = 0;
        regReq.rd = 1'b1;
        regReq.addr = a;
        tick();
        regReq.rd = 1'b0;
        while (rdValid !== 1'b1 && k < 3) begin
            tick();
            k++;
        end
        check(rdValid, 64'h1);
        d = rdData;
        tick();
    endtask

    task automatic waitWaiting();
        int k;
        k = 0;
        while (waiting !== 1'b1 && k < 50) begin
            tick();
            k++;
        end
        check(waiting, 64'h1);
    endtask

    // Edges from waiting seen high until the delayed trigger
    task automatic measure(int exp);
        int lat;
        lat = 0;
        while (trigEvent !== 1'b1 && lat < 400) begin
            tick();
            lat++;
        end
        check(lat, exp);
    endtask

    task automatic segPulse();
        segmentDone = 1'b1;
        tick();
        segmentDone = 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [63:0] d;
        logic [63:0] v;
        int dly;
        int n0;
        int k;
        logic sawOut;
        regReq = '0;
        cardRun = 1'b0;
        acqReady = 1'b0;
        segmentDone = 1'b0;
        srcEvents = '0;
        hubEnable = 1'b0;
        hubTrigIn = 1'b0;
        arstN = 1'b0;
        dly = 0;
        repeat (6) @(posedge refClk);
        #10 arstN = 1'b1;
        tick(4);

        check(armed, 64'h0);
        rd(`ADDR_TRIGGER_OR_SELECT, d);
        check(d, 64'h1);
        rd(`ADDR_TRIGGER_DELAY_COUNT, d);
        check(d, 64'h0);
        rd(`ADDR_MAX_DELAY_CAPABILITY, d);
        check(d, 64'h0000_003f_ffff_ffe0);
        wr(`ADDR_MAX_DELAY_CAPABILITY, {$random(seed), $random(seed)});
        rd(`ADDR_MAX_DELAY_CAPABILITY, d);
        check(d, 64'h0000_003f_ffff_ffe0);
        rd(`ADDR_CARD_COMMAND, d);
        check(d, 64'h0);
        rd(16'h1234, d);
        check(d, 64'h0);
        for (int i = 0; i < 4; i++) begin
            v = {32'h0, $random(seed)};
            wr(`ADDR_TRIGGER_OR_SELECT, v);
            rd(`ADDR_TRIGGER_OR_SELECT, d);
            check(d, v);
            v = {$random(seed), $random(seed)} & 64'h0000_003f_ffff_ffff;
            wr(`ADDR_TRIGGER_DELAY_COUNT, v);
            rd(`ADDR_TRIGGER_DELAY_COUNT, d);
            check(d, expDelay(v));
        end
        wr(`ADDR_TRIGGER_DELAY_COUNT, 64'hffff_ffff_ffff_ffff);
        rd(`ADDR_TRIGGER_DELAY_COUNT, d);
        check(d, expDelay(64'hffff_ffff_ffff_ffff));
        $display("test registers done");

        wr(`ADDR_CARD_COMMAND, 64'h08);
        check(armed, 64'h1);
        wr(`ADDR_CARD_COMMAND, 64'h28);
        check(armed, 64'h0);
        wr(`ADDR_CARD_COMMAND, 64'h08);
        check(armed, 64'h1);
        $display("test arm and disarm done");

        wr(`ADDR_TRIGGER_OR_SELECT, 64'h1);
        for (int i = 0; i < 3; i++) begin
            dly = (i == 0) ? 0 : (($random(seed) & 3) + 1) * 32;
            v = {32'h0, dly | ($random(seed) & 32'h1f)};
            wr(`ADDR_TRIGGER_DELAY_COUNT, v);
            acqReady = 1'b0;
            cardRun = 1'b1;
            n0 = nTrig;
            tick(6);
            check(waiting, 64'h0);
            check(nTrig, n0);
            acqReady = 1'b1;
            waitWaiting();
            measure(expLatency(v));
            cardRun = 1'b0;
            tick(2);
        end
        $display("test software trigger and delay done");

        wr(`ADDR_TRIGGER_OR_SELECT, 64'h4);
        srcEvents = $random(seed) | 32'h4;
        cardRun = 1'b1;
        waitWaiting();
        measure(expLatency(v));
        segPulse();
        waitWaiting();
        measure(expLatency(v));
        cardRun = 1'b0;
        tick(2);
        wr(`ADDR_TRIGGER_DELAY_COUNT, 64'h0);
        $display("test source path done");

        wr(`ADDR_CARD_COMMAND, 64'h20);
        cardRun = 1'b1;
        waitWaiting();
        n0 = nTrig;
        tick(10);
        check(nTrig, n0);
        wr(`ADDR_CARD_COMMAND, 64'h10);
        tick(4);
        check(nTrig, n0 + 1);
        check(waiting, 64'h0);
        // Force while the segment is still being recorded
        wr(`ADDR_CARD_COMMAND, 64'h10);
        check(nTrig, n0 + 1);
        check(waiting, 64'h0);
        segPulse();
        waitWaiting();
        tick(10);
        check(nTrig, n0 + 1);
        cardRun = 1'b0;
        tick(2);
        wr(`ADDR_CARD_COMMAND, 64'h10);
        cardRun = 1'b1;
        waitWaiting();
        tick(10);
        check(nTrig, n0 + 1);
        cardRun = 1'b0;
        srcEvents = '0;
        tick(2);
        $display("test force trigger done");

        wr(`ADDR_CARD_COMMAND, 64'h08);
        wr(`ADDR_TRIGGER_OR_SELECT, 64'h1);
        hubEnable = 1'b1;
        n0 = nTrig;
        cardRun = 1'b1;
        waitWaiting();
        sawOut = 1'b0;
        for (k = 0; k < 10; k++) begin
            if (hubTrigOut === 1'b1)
                sawOut = 1'b1;
            tick();
        end
        check(sawOut, 64'h1);
        check(nTrig, n0);
        hubTrigIn = 1'b1;
        tick();
        hubTrigIn = 1'b0;
        measure(expLatency(64'h0) - 1);
        hubEnable = 1'b0;
        cardRun = 1'b0;
        tick(2);
        $display("test hub path done");

        check(armed, 64'h1);
        arstN = 1'b0;
        tick(2);
        arstN = 1'b1;
        tick(4);
        check(armed, 64'h0);
        check(waiting, 64'h0);
        $display("test mid-run reset done");
        close_out();
    end

endmodule
`default_nettype wire
